/* File: fbo_pkg.sv */
package fbo_pkg;

  // **************************************************
  // Register map (byte addresses)
  // **************************************************
  localparam int           ADDR_W        = 12;
  localparam logic [11:0]  REG_INSTR     = 12'h000;
  localparam logic [11:0]  REG_PC        = 12'h004;
  localparam logic [11:0]  REG_FLAGS     = 12'h008;
  localparam logic [11:0]  REG_STAT      = 12'h00C;
  localparam logic [5:0]   REG_WREG_PAGE = 6'h01;
  localparam logic [0:0]   REG_FMEM_PAGE = 1'h1;

  // **************************************************
  // Field layouts and reset values
  // **************************************************
  localparam int           PC_W          = 23;
  localparam logic [22:0]  PC_RESET      = 23'h000000;
  localparam logic [22:0]  PC_STEP       = 23'h000002;
  localparam int           FLAGS_W       = 7;
  localparam logic [6:0]   FLAGS_RESET   = 7'h00;
  localparam int           FLG_C         = 0;
  localparam int           FLG_Z         = 1;
  localparam int           FLG_OV        = 2;
  localparam int           FLG_OA        = 3;
  localparam int           FLG_OB        = 4;
  localparam int           FLG_SA        = 5;
  localparam int           FLG_SB        = 6;
  localparam int           ST_BUSY       = 0;
  localparam int           ST_TAKEN      = 1;
  localparam int           ST_ILLEGAL    = 2;
  localparam int           ST_RANGE      = 3;

  // **************************************************
  // Opcodes (upper byte of the instruction)
  // **************************************************
  localparam logic [7:0]   OPC_BRA_OA    = 8'h0C;
  localparam logic [7:0]   OPC_BRA_OB    = 8'h0D;
  localparam logic [7:0]   OPC_BRA_SA    = 8'h0E;
  localparam logic [7:0]   OPC_BRA_SB    = 8'h0F;
  localparam logic [7:0]   OPC_BRA_OV    = 8'h30;
  localparam logic [7:0]   OPC_BRA_Z     = 8'h32;
  localparam logic [7:0]   OPC_BIT_SET_OP_W    = 8'hA0;
  localparam logic [7:0]   OPC_BIT_SET_OP_F    = 8'hA8;
  localparam logic [7:0]   OPC_BTG_F     = 8'hAA;
  localparam logic [7:0]   OPC_BSW       = 8'hAD;

  localparam logic [1:0]   RESP_OKAY     = 2'h0;
  localparam logic [1:0]   RESP_DECERR   = 2'h3;

  typedef enum logic [2:0] {
    AM_DIRECT  = 3'b000,
    AM_IND     = 3'b001,
    AM_POSTINC = 3'b010,
    AM_POSTDEC = 3'b011,
    AM_PREINC  = 3'b100,
    AM_PREDEC  = 3'b101
  } fbo_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_NOP  = 1'b1
  } fbo_state_t;

endpackage

/* File: fbo_core.sv */
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module fbo_core #(
  parameter int FILE_WORDS = 64
) (
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core status
  output logic             nop_slot,
  output logic [22:0]      pc_value
);

  localparam int FW = (FILE_WORDS > 1) ? $clog2(FILE_WORDS) : 1;

  // **************************************************
  // Storage
  // **************************************************
  logic [15:0]              wreg [16];
  logic [15:0]              fmem [FILE_WORDS];
  logic [22:0]              pc_r;
  logic [6:0]               flags_r;
  logic                     taken_r;
  logic                     illegal_r;
  logic                     range_r;
  fbo_pkg::fbo_state_t      state_r;
  logic [11:0]              aw_addr_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;

  // **************************************************
  // Helpers
  // **************************************************
  function automatic logic [15:0] put_bit(input logic [15:0] old, input logic [3:0] pos,
                                          input logic val);
    logic [15:0] r;
    r      = old;
    r[pos] = val;
    return r;
  endfunction

  function automatic logic word_ok(input logic [14:0] idx);
    return {17'h00000, idx} < FILE_WORDS;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_wreg(input logic [11:0] a);
    return a[11:6] == fbo_pkg::REG_WREG_PAGE;
  endfunction

  function automatic logic is_fmem(input logic [11:0] a);
    return a[11] == fbo_pkg::REG_FMEM_PAGE && {23'h000000, a[10:2]} < FILE_WORDS;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == fbo_pkg::REG_INSTR || a == fbo_pkg::REG_PC || a == fbo_pkg::REG_FLAGS
        || a == fbo_pkg::REG_STAT || is_wreg(a) || is_fmem(a);
  endfunction

  // **************************************************
  // Write channel acceptance
  // **************************************************
  logic wr_fire;
  logic issue;

  // An instruction write waits out the NOP slot so the pipeline never overlaps
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid
                && !(aw_addr_r == fbo_pkg::REG_INSTR && state_r == fbo_pkg::ST_NOP);
  assign issue   = wr_fire && aw_addr_r == fbo_pkg::REG_INSTR;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_addr_r     <= 12'h000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r     <= {s_axi_awaddr[11:2], 2'h0};
      end else if (wr_fire) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
      end else if (wr_fire) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fbo_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_r) ? fbo_pkg::RESP_OKAY : fbo_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // **************************************************
  // Instruction execute (combinational)
  // **************************************************
  logic [23:0]       ins;
  logic [7:0]        opc;
  logic [22:0]       pc_inc;
  logic [22:0]       pc_jump;
  logic              cond;
  logic              is_bra;
  logic [3:0]        s_idx;
  fbo_pkg::fbo_mode_t mode;
  logic              byte_op;
  logic [15:0]       ptr;
  logic [15:0]       step;
  logic [15:0]       ea;
  logic [3:0]        bitn;
  logic [3:0]        bitpos;
  logic              bitval;
  logic [15:0]       old_val;
  logic [14:0]       f_idx;
  logic              ex_taken;
  logic              ex_illegal;
  logic              ex_range;
  logic              ex_wreg_en;
  logic              ex_ptr_en;
  logic [15:0]       ex_ptr_val;
  logic              ex_mem_en;
  logic [14:0]       ex_mem_idx;
  logic [15:0]       ex_val;

  assign ins    = w_data_r[23:0];
  assign opc    = ins[23:16];
  assign s_idx  = ins[3:0];
  assign mode   = fbo_pkg::fbo_mode_t'(ins[6:4]);
  assign ptr    = wreg[s_idx];
  assign pc_inc = pc_r + fbo_pkg::PC_STEP;
  assign pc_jump = pc_inc + {{(fbo_pkg::PC_W - 17){ins[15]}}, ins[15:0], 1'b0};

  always_comb begin
    cond   = 1'b0;
    is_bra = 1'b1;
    unique case (opc)
      fbo_pkg::OPC_BRA_OA: cond = flags_r[fbo_pkg::FLG_OA];
      fbo_pkg::OPC_BRA_OB: cond = flags_r[fbo_pkg::FLG_OB];
      fbo_pkg::OPC_BRA_SA: cond = flags_r[fbo_pkg::FLG_SA];
      fbo_pkg::OPC_BRA_SB: cond = flags_r[fbo_pkg::FLG_SB];
      fbo_pkg::OPC_BRA_OV: cond = flags_r[fbo_pkg::FLG_OV];
      fbo_pkg::OPC_BRA_Z:  cond = flags_r[fbo_pkg::FLG_Z];
      default:             is_bra = 1'b0;
    endcase
  end

  always_comb begin
    byte_op    = (opc == fbo_pkg::OPC_BIT_SET_OP_W) && ins[10];
    // step one byte or one word
    step       = byte_op ? 16'h0001 : 16'h0002;
    ea         = ptr;
    ex_ptr_val = ptr;
    ex_ptr_en  = 1'b0;
    unique case (mode)
      fbo_pkg::AM_POSTINC: begin
        ex_ptr_val = ptr + step;
        ex_ptr_en  = 1'b1;
      end
      fbo_pkg::AM_POSTDEC: begin
        ex_ptr_val = ptr - step;
        ex_ptr_en  = 1'b1;
      end
      fbo_pkg::AM_PREINC: begin
        ea         = ptr + step;
        ex_ptr_val = ea;
        ex_ptr_en  = 1'b1;
      end
      fbo_pkg::AM_PREDEC: begin
        ea         = ptr - step;
        ex_ptr_val = ea;
        ex_ptr_en  = 1'b1;
      end
      default: begin
        ea = ptr;
      end
    endcase
  end

  always_comb begin
    ex_taken   = 1'b0;
    ex_illegal = 1'b0;
    ex_range   = 1'b0;
    ex_wreg_en = 1'b0;
    ex_mem_en  = 1'b0;
    ex_mem_idx = 15'h0000;
    ex_val     = 16'h0000;
    bitn       = 4'h0;
    bitpos     = 4'h0;
    bitval     = 1'b1;
    old_val    = 16'h0000;
    f_idx      = {3'h0, ins[12:1]};
    if (is_bra) begin
      ex_taken = cond;
    end else if (opc == fbo_pkg::OPC_BIT_SET_OP_F || opc == fbo_pkg::OPC_BTG_F) begin
      // word address plus four-bit bit number
      bitpos     = {ins[15:13], ins[0]};
      ex_range   = !word_ok(f_idx);
      old_val    = ex_range ? 16'h0000 : fmem[f_idx[FW-1:0]];
      bitval     = (opc == fbo_pkg::OPC_BIT_SET_OP_F) ? 1'b1 : !old_val[bitpos];
      ex_mem_en  = !ex_range;
      ex_mem_idx = f_idx;
      ex_val     = put_bit(old_val, bitpos, bitval);
    end else if (opc == fbo_pkg::OPC_BIT_SET_OP_W || opc == fbo_pkg::OPC_BSW) begin
      if (opc == fbo_pkg::OPC_BIT_SET_OP_W) begin
        bitn   = ins[15:12];
        bitval = 1'b1;
      end else begin
        bitn   = wreg[ins[14:11]][3:0];
        bitval = ins[15] ? !flags_r[fbo_pkg::FLG_Z] : flags_r[fbo_pkg::FLG_C];
      end
      // byte lane picks bits 0..7 of the addressed byte
      if (byte_op) begin
        bitpos = {(mode != fbo_pkg::AM_DIRECT) && ea[0], bitn[2:0]};
      end else begin
        bitpos = bitn;
      end
      if (ins[6:4] > 3'b101) begin
        ex_illegal = 1'b1;
      end else if (mode == fbo_pkg::AM_DIRECT) begin
        ex_wreg_en = 1'b1;
        ex_val     = put_bit(ptr, bitpos, bitval);
      end else begin
        ex_mem_idx = ea[15:1];
        ex_range   = !word_ok(ea[15:1]) || (!byte_op && ea[0]);
        old_val    = word_ok(ea[15:1]) ? fmem[ea[FW:1]] : 16'h0000;
        ex_mem_en  = !ex_range;
        ex_val     = put_bit(old_val, bitpos, bitval);
      end
    end else begin
      ex_illegal = 1'b1;
    end
  end

  // **************************************************
  // Architectural state
  // **************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_r <= fbo_pkg::PC_RESET;
    end else if (ce) begin
      if (issue) begin
        pc_r <= ex_taken ? pc_jump : pc_inc;
        if (ex_ptr_en && !ex_illegal && (opc == fbo_pkg::OPC_BIT_SET_OP_W || opc == fbo_pkg::OPC_BSW)) begin
          wreg[s_idx] <= ex_ptr_val;
        end
        if (ex_wreg_en) begin
          wreg[s_idx] <= ex_val;
        end
        if (ex_mem_en) begin
          fmem[ex_mem_idx[FW-1:0]] <= ex_val;
        end
      end else if (wr_fire) begin
        if (aw_addr_r == fbo_pkg::REG_PC) begin
          pc_r <= 23'(strb_merge({9'h000, pc_r}, w_data_r, w_strb_r));
        end else if (is_wreg(aw_addr_r)) begin
          wreg[aw_addr_r[5:2]] <= 16'(strb_merge({16'h0000, wreg[aw_addr_r[5:2]]},
                                                 w_data_r, w_strb_r));
        end else if (is_fmem(aw_addr_r)) begin
          fmem[aw_addr_r[FW+1:2]] <= 16'(strb_merge({16'h0000, fmem[aw_addr_r[FW+1:2]]},
                                                    w_data_r, w_strb_r));
        end
      end
    end
  end

  // Flags are written only by software; no instruction here touches them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_r <= fbo_pkg::FLAGS_RESET;
    end else if (ce) begin
      // only a bus write changes flags
      if (wr_fire && aw_addr_r == fbo_pkg::REG_FLAGS) begin
        flags_r <= 7'(strb_merge({25'h0000000, flags_r}, w_data_r, w_strb_r));
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      taken_r   <= 1'b0;
      illegal_r <= 1'b0;
      range_r   <= 1'b0;
    end else if (ce) begin
      if (issue) begin
        taken_r   <= ex_taken;
        illegal_r <= ex_illegal;
        range_r   <= ex_range;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r  <= fbo_pkg::ST_IDLE;
      nop_slot <= 1'b0;
    end else if (ce) begin
      unique case (state_r)
        fbo_pkg::ST_IDLE: begin
          // taken jump adds the NOP cycle
          if (issue && ex_taken) begin
            state_r  <= fbo_pkg::ST_NOP;
            nop_slot <= 1'b1;
          end
        end
        fbo_pkg::ST_NOP: begin
          state_r  <= fbo_pkg::ST_IDLE;
          nop_slot <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_value <= fbo_pkg::PC_RESET;
    end else if (ce) begin
      pc_value <= pc_r;
    end
  end

  // **************************************************
  // Read channel
  // **************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    if (s_axi_araddr[11:2] == fbo_pkg::REG_PC[11:2]) begin
      rd_word = {9'h000, pc_r};
    end else if (s_axi_araddr[11:2] == fbo_pkg::REG_FLAGS[11:2]) begin
      rd_word = {25'h0000000, flags_r};
    end else if (s_axi_araddr[11:2] == fbo_pkg::REG_STAT[11:2]) begin
      rd_word[fbo_pkg::ST_BUSY]    = state_r == fbo_pkg::ST_NOP;
      rd_word[fbo_pkg::ST_TAKEN]   = taken_r;
      rd_word[fbo_pkg::ST_ILLEGAL] = illegal_r;
      rd_word[fbo_pkg::ST_RANGE]   = range_r;
    end else if (is_wreg({s_axi_araddr[11:2], 2'h0})) begin
      rd_word = {16'h0000, wreg[s_axi_araddr[5:2]]};
    end else if (is_fmem({s_axi_araddr[11:2], 2'h0})) begin
      rd_word = {16'h0000, fmem[s_axi_araddr[FW+1:2]]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= fbo_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= is_mapped({s_axi_araddr[11:2], 2'h0}) ? fbo_pkg::RESP_OKAY
                                                                : fbo_pkg::RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: fbo_core_properties.sv */
`timescale 1ns/1ps
module fbo_core_properties (
  // Clock and control
  input logic        core_clk,
  input logic        rst,
  input logic        ce,
  // Write side
  input logic [11:0] s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // Read side
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Core status
  input logic        nop_slot,
  input logic [22:0] pc_value
);
  logic [11:0] aq_r;
  logic [31:0] dq_r;
  logic [6:0]  fq_r;
  logic        bq_r;
  logic        isj;
  logic        cond;
  logic        jmp;
  logic [22:0] disp;

  // Shadow of the last write, so a jump can be judged when it answers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aq_r <= 12'h000;
      dq_r <= 32'h00000000;
      fq_r <= 7'h00;
      bq_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) aq_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) dq_r <= s_axi_wdata;
      if (s_axi_bvalid && !bq_r && aq_r == fbo_pkg::REG_FLAGS) fq_r <= dq_r[6:0];
      bq_r <= s_axi_bvalid;
    end
  end

  always_comb begin
    isj = 1'b1;
    case (dq_r[23:16])
      fbo_pkg::OPC_BRA_OA: cond = fq_r[fbo_pkg::FLG_OA];
      fbo_pkg::OPC_BRA_OB: cond = fq_r[fbo_pkg::FLG_OB];
      fbo_pkg::OPC_BRA_SA: cond = fq_r[fbo_pkg::FLG_SA];
      fbo_pkg::OPC_BRA_SB: cond = fq_r[fbo_pkg::FLG_SB];
      fbo_pkg::OPC_BRA_OV: cond = fq_r[fbo_pkg::FLG_OV];
      fbo_pkg::OPC_BRA_Z:  cond = fq_r[fbo_pkg::FLG_Z];
      default: begin
        isj = 1'b0;
        cond = 1'b0;
      end
    endcase
  end

  assign jmp  = s_axi_bvalid && !bq_r && aq_r == fbo_pkg::REG_INSTR && isj;
  assign disp = {{6{dq_r[15]}}, dq_r[15:0], 1'b0};

  // A frozen clock enable stalls everything, so checks pause with it
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);

  property p_nop_one;
    nop_slot |=> !nop_slot;
  endproperty
  a_nop_one: assert property (p_nop_one)
    else $error("nop slot held longer than one cycle");

  property p_nop_resp;
    $rose(nop_slot) |-> $rose(s_axi_bvalid);
  endproperty
  a_nop_resp: assert property (p_nop_resp)
    else $error("nop slot without an instruction completing");

  property p_jump_cond;
    jmp |-> nop_slot == cond;
  endproperty
  a_jump_cond: assert property (p_jump_cond)
    else $error("jump decision does not match its flag");

  property p_jump_pc;
    jmp |=> pc_value == $past(pc_value) + 23'h000002 + ($past(nop_slot) ? disp : 23'h0);
  endproperty
  a_jump_pc: assert property (p_jump_pc)
    else $error("program counter after jump is wrong");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before it was taken");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before it was taken");

  property p_r_next;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_next: assert property (p_r_next)
    else $error("read answer not one cycle after address");

  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !nop_slot
      |-> ##[2:3] s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat)
    else $error("write response late");
endmodule

bind fbo_core fbo_core_properties i_fbo_core_properties (
  .core_clk(core_clk), .rst(rst), .ce(ce),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .nop_slot(nop_slot), .pc_value(pc_value));

/* File: fbo_core_tb_top.sv */
`timescale 1ns/1ps
module fbo_core_tb_top;
  localparam int FW = 16;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        nop_slot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [22:0] pc_value;
  int          error_cnt = 0;
  int          checks = 0;
  logic [31:0] seed = 32'hD8F7;
  logic [1:0]  qb[$];
  logic [33:0] qr[$];
  logic [7:0]  opcs[6] = '{fbo_pkg::OPC_BRA_OA, fbo_pkg::OPC_BRA_OB, fbo_pkg::OPC_BRA_SA,
                           fbo_pkg::OPC_BRA_SB, fbo_pkg::OPC_BRA_OV, fbo_pkg::OPC_BRA_Z};
  int          fbs[6] = '{fbo_pkg::FLG_OA, fbo_pkg::FLG_OB, fbo_pkg::FLG_SA,
                          fbo_pkg::FLG_SB, fbo_pkg::FLG_OV, fbo_pkg::FLG_Z};

  always #50 core_clk = ~core_clk;

  fbo_core #(.FILE_WORDS(FW)) i_fbo_core (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .nop_slot(nop_slot), .pc_value(pc_value));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] fa(int k);
    return {fbo_pkg::REG_FMEM_PAGE, 11'(4 * k)};
  endfunction

  function automatic logic [11:0] wa(logic [3:0] r);
    return {fbo_pkg::REG_WREG_PAGE, r, 2'b00};
  endfunction

  task automatic results;
    $display("Summary: %0d errors in %0d checks", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_b(logic [1:0] e, logic [1:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error bresp expected %h seen %h", e, s);
    end
  endtask

  task automatic chk_r(logic [33:0] e, logic [33:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error rresp_rdata expected %h seen %h", e, s);
    end
  endtask

  // Answers are judged here, oldest expectation first
  always @(posedge core_clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk_b(qb.size() ? qb.pop_front() : 2'bxx, s_axi_bresp);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk_r(qr.size() ? qr.pop_front() : 34'hx, {s_axi_rresp, s_axi_rdata});
  end

  // Ready on the answer channel starts low at random to make the slave hold
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] e = fbo_pkg::RESP_OKAY);
    logic [31:0] r;
    logic bd;
    r = rnd();
    bd = 1'b0;
    qb.push_back(e);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= r[0];
    for (int n = 0; n < 40 && !bd; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) bd = 1'b1;
      else if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (!bd) begin
      error_cnt++;
      results();
    end
    @(posedge core_clk);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] e = fbo_pkg::RESP_OKAY);
    logic [31:0] r;
    logic bd;
    r = rnd();
    bd = 1'b0;
    qr.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= r[0];
    for (int n = 0; n < 40 && !bd; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) bd = 1'b1;
      else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (!bd) begin
      error_cnt++;
      results();
    end
    @(posedge core_clk);
  endtask

  initial begin
    logic [31:0] r;
    logic [22:0] pc;
    logic [15:0] off, d, e, ea, w0, w1;
    logic [6:0]  fl;
    logic [3:0]  b, rg;
    logic        tk, bt;
    int          k, st;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(fbo_pkg::REG_PC, 32'h0);
    rd(fbo_pkg::REG_FLAGS, 32'h0);
    rd(fbo_pkg::REG_STAT, 32'h0);
    // Unmapped address answers with a decode error both ways
    wr(12'h010, 32'h0000FFFF, fbo_pkg::RESP_DECERR);
    rd(12'h010, 32'h0, fbo_pkg::RESP_DECERR);
    // Every jump code, taken and not, with both offset extremes
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      pc = {r[22:1], 1'b0};
      off = i == 0 ? 16'h8000 : i == 1 ? 16'h7FFF : r[31:16];
      tk = i < 6;
      fl = tk ? 7'h01 << fbs[i % 6] : ~(7'h01 << fbs[i % 6]);
      wr(fbo_pkg::REG_PC, {9'h0, pc});
      wr(fbo_pkg::REG_FLAGS, {25'h0, fl});
      wr(fbo_pkg::REG_INSTR, {8'h00, opcs[i % 6], off});
      pc = pc + 23'h000002 + (tk ? {{6{off[15]}}, off, 1'b0} : 23'h0);
      rd(fbo_pkg::REG_PC, {9'h0, pc});
      rd(fbo_pkg::REG_PC, {9'h0, pc});
      rd(fbo_pkg::REG_FLAGS, {25'h0, fl});
      rd(fbo_pkg::REG_STAT, {30'h0, tk, 1'b0});
    end
    // Set then toggle twice a file bit
    r = rnd();
    k = 2 + r[3:0] % 12;
    b = r[7:4];
    d = r[31:16];
    wr(fa(k), {16'h0, d});
    wr(fbo_pkg::REG_INSTR, {8'h00, fbo_pkg::OPC_BIT_SET_OP_F, b[3:1], 12'(k), b[0]});
    e = d | (16'h1 << b);
    rd(fa(k), {16'h0, e});
    for (int j = 0; j < 2; j++) begin
      wr(fbo_pkg::REG_INSTR, {8'h00, fbo_pkg::OPC_BTG_F, b[3:1], 12'(k), b[0]});
      e[b] = ~e[b];
      rd(fa(k), {16'h0, e});
    end
    rd(fbo_pkg::REG_FLAGS, {25'h0, fl});
    // Working register bit set over all modes, mode 6 refused
    for (int m = 0; m < 7; m++) begin
      r = rnd();
      rg = r[3:0];
      k = 2 + r[11:8] % 12;
      d = r[31:16];
      bt = m == 3 || m == 5;
      b = bt ? {1'b0, r[6:4]} : r[7:4];
      st = bt ? 1 : 2;
      ea = 16'(2 * k) + (bt ? {15'h0, r[12]} : 16'h0);
      w0 = m == 4 ? ea - 16'(st) : m == 5 ? ea + 16'(st) : ea;
      w1 = m == 2 ? ea + 16'(st) : m == 3 ? ea - 16'(st) : ea;
      wr(wa(rg), {16'h0, m == 0 ? d : w0});
      if (m != 0) wr(fa(k), {16'h0, d});
      wr(fbo_pkg::REG_INSTR, {8'h00, fbo_pkg::OPC_BIT_SET_OP_W, b, 1'b0, bt, 3'b000, 3'(m), rg});
      e = d | (m == 6 ? 16'h0 : 16'h1 << (bt ? {ea[0], b[2:0]} : b));
      rd(m == 0 ? wa(rg) : fa(k), {16'h0, e});
      if (m != 0) rd(wa(rg), {16'h0, m == 6 ? w0 : w1});
      rd(fbo_pkg::REG_STAT, m == 6 ? 32'h1 << fbo_pkg::ST_ILLEGAL : 32'h0);
    end
    // Flag into bit, both flag selections
    for (int z = 0; z < 2; z++) begin
      r = rnd();
      rg = r[3:0];
      d = r[31:16];
      fl = {5'h00, r[9:8]};
      wr(fbo_pkg::REG_FLAGS, {25'h0, fl});
      // Upper bits of the index register are noise: only its low four count
      wr(wa(rg + 4'h1), {16'h0, r[31:20], r[7:4]});
      wr(wa(rg), {16'h0, d});
      wr(fbo_pkg::REG_INSTR, {8'h00, fbo_pkg::OPC_BSW, z[0], 4'(rg + 4'h1), 7'h00, rg});
      e = d;
      e[r[7:4]] = z ? ~fl[fbo_pkg::FLG_Z] : fl[fbo_pkg::FLG_C];
      rd(wa(rg), {16'h0, e});
    end
    results();
  end
endmodule
